/* File: hdl/msp_regs.svh */
// Offsets, field positions and reset values for the mode/protect block.
// Assumes it is included by its bare name from the top module and the bench.
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - Mode pin low at reset release selects special test mode.
// - Test entry loads priority/mode with 50h, protection disabled.
// - Test bit set: relocation register writable any number of times.
// - Clearing test bit arms protection, then exactly one more write allowed.
// - Visibility bit one: special register reads leave data drivers off.
// - Visibility bit zero: special register reads drive their contents.
// - In test mode only the first write to the visibility bit counts.
// - Leaving test mode forces the visibility bit to zero.
// - Respond only while chip select is low; otherwise unselected.
// - Mode pin high at reset release selects normal mode.
// - Normal entry loads priority/mode with 00h, one relocation write allowed.
// - Normal mode ignores priority/mode writes until the next reset.
// - Protection locks only on an actual write, never on elapsed time.
// - Input strobe gets an extra synchroniser stage before the latch.
// - Port B and C outputs change after the falling clock edge.
// - Output strobe changes on the rising clock edge.
// - Mode pin latched at reset release, inverse held in test bit.
// - Reset pin synchronised, recognised only when low two clocks.
// - Relocation low nibble must match address bits 15 to 12.
// - Relocation upper nibble ignores writes and reads as zero.
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH

//------------------------------------------------------------
// Register byte offsets within the 4K block
//------------------------------------------------------------
`define MSP_OFF_RELOC 12'h000
`define MSP_OFF_PRIO 12'h004
`define MSP_OFF_PORTB 12'h008
`define MSP_OFF_PORTC 12'h00c
`define MSP_OFF_DDRC 12'h010
`define MSP_OFF_LATCH 12'h014

//------------------------------------------------------------
// Fields and reset values
//------------------------------------------------------------
`define MSP_TEST_BIT 6
`define MSP_RVB_BIT 4
`define MSP_PRIO_OTH_MASK 8'haf
`define MSP_PRIO_TEST_RST 8'h50
`define MSP_PRIO_NORM_RST 8'h00
`define MSP_RELOC_RST 4'h1

`endif

/* File: hdl/msp_pkg.sv */
// Types shared by the mode/protect block.
// Assumes nothing beyond the register header.
package msp_pkg;
    // Decoded register selection
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_RELOC = 3'b001,
        SEL_PRIO = 3'b010,
        SEL_PORTB = 3'b011,
        SEL_PORTC = 3'b100,
        SEL_DDRC = 3'b101,
        SEL_LATCH = 3'b110
    } msp_sel_t;
endpackage : msp_pkg

/* File: hdl/msp_top.sv */
// Mode select, relocation protect and port strobe logic behind an APB slave.
// Assumes APB on pclk; reset, mode, strobe and port C pins are asynchronous.
`timescale 1ns/1ns
`include "msp_regs.svh"

module msp_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device pins in
    input wire logic reset_pin_n,
    input wire logic mode_sel,
    input wire logic chip_sel_n,
    input wire logic input_strobe,
    input wire logic [7:0] port_c_in,
    // Device pins out
    output logic bus_drive_en,
    output logic test_mode,
    output logic output_strobe,
    output logic [7:0] port_b_out,
    output logic [7:0] port_c_out,
    output logic [7:0] port_c_oe
);

    //------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------
    // Used by both the read (setup) and write (access) paths
    function automatic msp_pkg::msp_sel_t decode(input logic [15:0] addr,
                                                 input logic [3:0] reloc);
        msp_pkg::msp_sel_t s;
        s = msp_pkg::SEL_NONE;
        if (addr[15:12] == reloc) begin
            unique case (addr[11:0])
                `MSP_OFF_RELOC: s = msp_pkg::SEL_RELOC;
                `MSP_OFF_PRIO: s = msp_pkg::SEL_PRIO;
                `MSP_OFF_PORTB: s = msp_pkg::SEL_PORTB;
                `MSP_OFF_PORTC: s = msp_pkg::SEL_PORTC;
                `MSP_OFF_DDRC: s = msp_pkg::SEL_DDRC;
                `MSP_OFF_LATCH: s = msp_pkg::SEL_LATCH;
                default: s = msp_pkg::SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    // Bits: 10 reset, 9 mode, 8 strobe, 7:0 port C
    logic [10:0] sync1_q, sync1_d;
    logic [10:0] sync2_q, sync2_d;
    logic rst3_q, rst3_d;
    logic stb3_q, stb3_d;
    logic stb4_q, stb4_d;
    logic rst_rec;
    logic stb_edge;

    // Next values; stage one feeds stage two only
    always_comb begin
        sync1_d = sync1_q;
        sync2_d = sync2_q;
        rst3_d = rst3_q;
        stb3_d = stb3_q;
        stb4_d = stb4_q;
        if (clk_en) begin
            sync1_d = {reset_pin_n, mode_sel, input_strobe, port_c_in};
            sync2_d = sync1_q;
            rst3_d = sync2_q[10];
            stb3_d = sync2_q[8];
            stb4_d = stb3_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 11'h000;
            sync2_q <= 11'h000;
            rst3_q <= 1'b0;
            stb3_q <= 1'b0;
            stb4_q <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            rst3_q <= rst3_d;
            stb3_q <= stb3_d;
            stb4_q <= stb4_d;
        end
    end

    // A one-cycle glitch on the pin is filtered out
    assign rst_rec = !sync2_q[10] && !rst3_q;
    // Rising edge only, taken after the extra stage
    assign stb_edge = stb3_q && !stb4_q;

    //------------------------------------------------------------
    // Core state and APB slave
    //------------------------------------------------------------
    logic [3:0] reloc_q, reloc_d;
    logic locked_q, locked_d;
    logic test_q, test_d;
    logic rvb_q, rvb_d;
    logic rvb_wr_q, rvb_wr_d;
    logic [7:0] oth_q, oth_d;
    logic [7:0] portb_q, portb_d;
    logic [7:0] portc_q, portc_d;
    logic [7:0] ddrc_q, ddrc_d;
    logic [7:0] pcl_q, pcl_d;
    logic ostb_q, ostb_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic drive_q, drive_d;
    logic [31:0] prdata_q, prdata_d;
    logic setup;
    logic wr;
    logic special;
    logic [7:0] prio_val;
    logic [7:0] prio_rst;
    msp_pkg::msp_sel_t rsel;
    msp_pkg::msp_sel_t wsel;

    assign setup = psel && !penable;
    // Unselected or reset cycles decode to nothing
    assign rsel = (chip_sel_n || rst_rec) ? msp_pkg::SEL_NONE
                                          : decode(paddr, reloc_q);
    assign wsel = decode(paddr, reloc_q);
    // Error answer already blocks unselected writes
    assign wr = psel && penable && pready_q && pwrite && !pslverr_q;
    assign special = (rsel == msp_pkg::SEL_RELOC) || (rsel == msp_pkg::SEL_PRIO);
    assign prio_val = oth_q | ({7'h00, test_q} << `MSP_TEST_BIT)
                    | ({7'h00, rvb_q} << `MSP_RVB_BIT);
    // Mode pin high gives normal, low gives test
    assign prio_rst = sync2_q[9] ? `MSP_PRIO_NORM_RST : `MSP_PRIO_TEST_RST;

    // Next values of registers and bus answer
    always_comb begin
        reloc_d = reloc_q;
        locked_d = locked_q;
        test_d = test_q;
        rvb_d = rvb_q;
        rvb_wr_d = rvb_wr_q;
        oth_d = oth_q;
        portb_d = portb_q;
        portc_d = portc_q;
        ddrc_d = ddrc_q;
        pcl_d = pcl_q;
        ostb_d = ostb_q;
        pready_d = pready_q;
        pslverr_d = pslverr_q;
        drive_d = drive_q;
        prdata_d = prdata_q;
        if (clk_en) begin
            // Answer is prepared in setup, shown in access
            pready_d = setup;
            pslverr_d = setup && (rsel == msp_pkg::SEL_NONE);
            drive_d = 1'b0;
            prdata_d = 32'h0000_0000;
            ostb_d = wr && (wsel == msp_pkg::SEL_PORTB);
            if (setup && !pwrite) begin
                // Hidden reads keep drivers off and return zero
                drive_d = (rsel != msp_pkg::SEL_NONE) && !(special && rvb_q);
                unique case (rsel)
                    msp_pkg::SEL_RELOC: prdata_d = {28'h0000000, reloc_q};
                    msp_pkg::SEL_PRIO: prdata_d = {24'h000000, prio_val};
                    msp_pkg::SEL_PORTB: prdata_d = {24'h000000, portb_q};
                    msp_pkg::SEL_PORTC: prdata_d = {24'h000000, portc_q};
                    msp_pkg::SEL_DDRC: prdata_d = {24'h000000, ddrc_q};
                    msp_pkg::SEL_LATCH: prdata_d = {24'h000000, pcl_q};
                    msp_pkg::SEL_NONE: prdata_d = 32'h0000_0000;
                endcase
                if (special && rvb_q) begin
                    prdata_d = 32'h0000_0000;
                end
            end
            if (stb_edge) begin
                pcl_d = sync2_q[7:0];
            end
            if (wr) begin
                unique case (wsel)
                    msp_pkg::SEL_RELOC: begin
                        // Only a real write locks; no timeout exists
                        if (test_q || !locked_q) begin
                            reloc_d = pwdata[3:0];
                            locked_d = !test_q;
                        end
                    end
                    msp_pkg::SEL_PRIO: begin
                        if (test_q) begin
                            oth_d = pwdata[7:0] & `MSP_PRIO_OTH_MASK;
                            if (!pwdata[`MSP_TEST_BIT]) begin
                                // Test mode cannot be re-entered by software
                                test_d = 1'b0;
                                rvb_d = 1'b0;
                                locked_d = 1'b0;
                            end else if (!rvb_wr_q) begin
                                rvb_d = pwdata[`MSP_RVB_BIT];
                                rvb_wr_d = 1'b1;
                            end
                        end
                    end
                    msp_pkg::SEL_PORTB: portb_d = pwdata[7:0];
                    msp_pkg::SEL_PORTC: portc_d = pwdata[7:0];
                    msp_pkg::SEL_DDRC: ddrc_d = pwdata[7:0];
                    default: begin
                    end
                endcase
            end
            if (rst_rec) begin
                // Held each cycle, so the last sample before release wins
                reloc_d = `MSP_RELOC_RST;
                locked_d = 1'b0;
                test_d = prio_rst[`MSP_TEST_BIT];
                rvb_d = prio_rst[`MSP_RVB_BIT];
                oth_d = prio_rst & `MSP_PRIO_OTH_MASK;
                rvb_wr_d = 1'b0;
                portb_d = 8'h00;
                portc_d = 8'h00;
                ddrc_d = 8'h00;
                pcl_d = 8'h00;
                ostb_d = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reloc_q <= `MSP_RELOC_RST;
            locked_q <= 1'b0;
            test_q <= 1'b0;
            rvb_q <= 1'b0;
            rvb_wr_q <= 1'b0;
            oth_q <= 8'h00;
            portb_q <= 8'h00;
            portc_q <= 8'h00;
            ddrc_q <= 8'h00;
            pcl_q <= 8'h00;
            ostb_q <= 1'b0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            drive_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            reloc_q <= reloc_d;
            locked_q <= locked_d;
            test_q <= test_d;
            rvb_q <= rvb_d;
            rvb_wr_q <= rvb_wr_d;
            oth_q <= oth_d;
            portb_q <= portb_d;
            portc_q <= portc_d;
            ddrc_q <= ddrc_d;
            pcl_q <= pcl_d;
            ostb_q <= ostb_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            drive_q <= drive_d;
            prdata_q <= prdata_d;
        end
    end

    //------------------------------------------------------------
    // Port outputs on the falling edge
    //------------------------------------------------------------
    logic [7:0] pbo_q, pbo_d;
    logic [7:0] pco_q, pco_d;
    logic [7:0] pce_q, pce_d;

    // Half a cycle later than the register write
    always_comb begin
        pbo_d = pbo_q;
        pco_d = pco_q;
        pce_d = pce_q;
        if (clk_en) begin
            pbo_d = portb_q;
            pco_d = portc_q;
            pce_d = ddrc_q;
        end
    end

    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            pbo_q <= 8'h00;
            pco_q <= 8'h00;
            pce_q <= 8'h00;
        end else begin
            pbo_q <= pbo_d;
            pco_q <= pco_d;
            pce_q <= pce_d;
        end
    end

    // Every output straight from a flop
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign bus_drive_en = drive_q;
    assign test_mode = test_q;
    assign output_strobe = ostb_q;
    assign port_b_out = pbo_q;
    assign port_c_out = pco_q;
    assign port_c_oe = pce_q;

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TEST_ENTRY: assert property (clk_en && rst_rec && !sync2_q[9] |=>
        test_q && rvb_q && !locked_q && oth_q == 8'h00)
        else $error("test mode entry values wrong");

    AST_NORMAL_ENTRY: assert property (clk_en && rst_rec && sync2_q[9] |=>
        !test_q && !rvb_q && !locked_q && reloc_q == 4'h1)
        else $error("normal mode entry values wrong");

    AST_TEST_NOLOCK: assert property (test_q |-> !locked_q)
        else $error("protection engaged in test mode");

    AST_ONE_MORE: assert property ($fell(test_q) |-> !locked_q && !rvb_q)
        else $error("leaving test mode did not arm one write");

    AST_HIDDEN: assert property (clk_en && setup && !pwrite && special && rvb_q
        |=> !bus_drive_en && prdata == 32'h0000_0000 && pready)
        else $error("hidden read drove the bus");

    AST_SHOWN: assert property (clk_en && setup && !pwrite && rsel == msp_pkg::SEL_RELOC
        && !rvb_q |=> bus_drive_en && prdata == {28'h0000000, $past(reloc_q)})
        else $error("visible read did not drive contents");

    AST_CS_OFF: assert property (clk_en && setup && chip_sel_n
        |=> pready && pslverr && !bus_drive_en)
        else $error("unselected cycle answered");

    AST_PRIO_FROZEN: assert property (!test_q && !rst_rec
        |=> $stable(prio_val))
        else $error("priority register changed in normal mode");

    AST_LOCK_HOLD: assert property (locked_q && !rst_rec |=> $stable(reloc_q))
        else $error("locked relocation register changed");

    AST_RVB_ONCE: assert property (rvb_wr_q && test_q && !rst_rec
        |=> $stable(rvb_q) || !test_q)
        else $error("second visibility write accepted");

    // A strobe edge during device reset is overridden by the reset clear
    AST_STROBE: assert property (clk_en && stb_edge && !rst_rec
        |=> pcl_q == $past(sync2_q[7:0]))
        else $error("input latch missed strobe");

    AST_OSTB: assert property (clk_en && wr && wsel == msp_pkg::SEL_PORTB && !rst_rec
        |=> output_strobe ##1 (!output_strobe || !$past(clk_en)))
        else $error("output strobe not raised after port B write");

endmodule : msp_top

/* File: sim/msp_host_model.sv */
// Host-side pin model: device reset pin, mode pin, chip select, port C strobe source.
// Assumes the bench calls its tasks right after a rising pclk edge.
`timescale 1ns/1ns

module msp_host_model (
    // Clock
    input wire logic pclk,
    // Pins toward the device
    output logic reset_pin_n,
    output logic mode_sel,
    output logic chip_sel_n,
    output logic input_strobe,
    output logic [7:0] port_c_in
);
    //----------------------------------------
    // Pin drivers
    //----------------------------------------
    // Device held in reset until the bench releases it
    initial begin
        reset_pin_n = 1'b0;
        mode_sel = 1'b1;
        chip_sel_n = 1'b0;
        input_strobe = 1'b0;
        port_c_in = 8'h5a;
    end

    // Reset low for lo cycles; mode held well past release so the latch sees it
    task automatic dev_reset(input logic mode, input int lo);
        mode_sel <= mode;
        reset_pin_n <= 1'b0;
        repeat (lo) @(posedge pclk);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : dev_reset

    // Chip select level, settles one edge before the next access
    task automatic set_cs(input logic v);
        chip_sel_n <= v;
        @(posedge pclk);
    endtask : set_cs

    // One rising strobe edge; data held past the synchroniser, then scrambled
    task automatic strobe(input logic [7:0] v);
        port_c_in <= v;
        input_strobe <= 1'b1;
        @(posedge pclk);
        input_strobe <= 1'b0;
        repeat (7) @(posedge pclk);
        port_c_in <= ~v;
    endtask : strobe
endmodule : msp_host_model

/* File: sim/tb.sv */
// Self-checking bench for the mode/protect block over APB.
// Assumes the register header and the host pin model are compiled first.
`timescale 1ns/1ns
`include "msp_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); end end

module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, seed_r;
    logic reset_pin_n, mode_sel, chip_sel_n, input_strobe, bus_drive_en;
    logic test_mode, output_strobe, clk_en;
    logic [7:0] port_c_in, port_b_out, port_c_out, port_c_oe, v;
    logic [3:0] nib;
    logic [34:0] exp_q[$];
    logic [34:0] ex;
    int num_errors = 0;
    int num_checks = 0;
    int output_strobe_cnt = 0;
    int s0;

    //----------------------------------------
    // Design, pin model, clock
    //----------------------------------------
    msp_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .mode_sel(mode_sel), .chip_sel_n(chip_sel_n), .input_strobe(input_strobe),
        .port_c_in(port_c_in), .bus_drive_en(bus_drive_en), .test_mode(test_mode),
        .output_strobe(output_strobe), .port_b_out(port_b_out),
        .port_c_out(port_c_out), .port_c_oe(port_c_oe));
    msp_host_model host (.pclk(pclk), .reset_pin_n(reset_pin_n), .mode_sel(mode_sel),
        .chip_sel_n(chip_sel_n), .input_strobe(input_strobe), .port_c_in(port_c_in));

    // 20 MHz
    always #25 pclk = ~pclk;

    //----------------------------------------
    // APB master
    //----------------------------------------
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] off, input logic [7:0] d,
                       input logic err, input logic drv, input logic [7:0] q);
        int n;
        logic [31:0] r;
        n = 0;
        r = $urandom();
        exp_q.push_back({~w, err, drv, 24'h000000, q});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {nib, off};
        pwdata <= {r[31:8], d};
        @(posedge pclk);
        penable <= 1'b1;
        // pready is read at the rising edge, before that edge updates it
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) num_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] off, input logic [7:0] d, input logic err = 1'b0);
        apb(1'b1, off, d, err, 1'b0, 8'h00);
    endtask : wr

    task automatic rd(input logic [11:0] off, input logic err, input logic drv,
                      input logic [7:0] q);
        apb(1'b0, off, 8'h00, err, drv, q);
    endtask : rd

    //----------------------------------------
    // Result watcher
    //----------------------------------------
    // Oldest note against each answer; settled at the falling edge
    always @(negedge pclk) begin
        if (output_strobe === 1'b1) output_strobe_cnt++;
        if (psel && penable && pready === 1'b1) begin
            ex = exp_q.pop_front();
            `CHK(pslverr, ex[33])
            if (ex[34]) `CHK({bus_drive_en, prdata}, ex[32:0])
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // Run needs well under 2000 cycles
    initial begin
        #(50 * 20000);
        num_errors++;
        $display("wrong value at %0t: run hung", $time);
        tally_and_finish;
    end

    //----------------------------------------
    // Scenarios
    //----------------------------------------
    initial begin
        pclk = 1'b0;
        clk_en = 1'b1;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
        nib = `MSP_RELOC_RST;
        seed_r = $urandom(40);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Normal entry; long idle first, protection must not time out
        host.dev_reset(1'b1, 3);
        `CHK(test_mode, 1'b0)
        rd(`MSP_OFF_PRIO, 1'b0, 1'b1, `MSP_PRIO_NORM_RST);
        wr(`MSP_OFF_PRIO, 8'hff);
        rd(`MSP_OFF_PRIO, 1'b0, 1'b1, 8'h00);
        repeat (100) @(posedge pclk);
        wr(`MSP_OFF_RELOC, 8'hf3);
        nib = 4'h3;
        rd(`MSP_OFF_RELOC, 1'b0, 1'b1, 8'h03);
        wr(`MSP_OFF_RELOC, 8'h05);
        rd(`MSP_OFF_RELOC, 1'b0, 1'b1, 8'h03);
        nib = 4'h1;
        rd(`MSP_OFF_PRIO, 1'b1, 1'b0, 8'h00);
        nib = 4'h3;
        host.set_cs(1'b1);
        rd(`MSP_OFF_RELOC, 1'b1, 1'b0, 8'h00);
        host.set_cs(1'b0);
        // Too short a reset pulse is filtered out
        host.dev_reset(1'b0, 1);
        rd(`MSP_OFF_RELOC, 1'b0, 1'b1, 8'h03);
        // Test entry: mid-run reset restores mode-dependent state
        host.dev_reset(1'b0, 2);
        nib = `MSP_RELOC_RST;
        `CHK(test_mode, 1'b1)
        rd(`MSP_OFF_PRIO, 1'b0, 1'b0, 8'h00);
        rd(`MSP_OFF_RELOC, 1'b0, 1'b0, 8'h00);
        for (int i = 2; i < 8; i += 2) begin
            wr(`MSP_OFF_RELOC, 8'(i));
            nib = 4'(i);
        end
        rd(`MSP_OFF_RELOC, 1'b0, 1'b0, 8'h00);
        wr(`MSP_OFF_PRIO, 8'h40);
        rd(`MSP_OFF_PRIO, 1'b0, 1'b1, 8'h40);
        wr(`MSP_OFF_PRIO, 8'h5a);
        rd(`MSP_OFF_PRIO, 1'b0, 1'b1, 8'h4a);
        wr(`MSP_OFF_PRIO, 8'h00);
        `CHK(test_mode, 1'b0)
        rd(`MSP_OFF_PRIO, 1'b0, 1'b1, 8'h00);
        wr(`MSP_OFF_RELOC, 8'h09);
        nib = 4'h9;
        wr(`MSP_OFF_RELOC, 8'h0b);
        rd(`MSP_OFF_RELOC, 1'b0, 1'b1, 8'h09);
        // Port outputs, output strobe and strobed input latch
        for (int i = 0; i < 3; i++) begin
            v = 8'($urandom());
            s0 = output_strobe_cnt;
            wr(`MSP_OFF_PORTB, v);
            `CHK(port_b_out, v)
            `CHK(output_strobe_cnt, s0 + 1)
            wr(`MSP_OFF_PORTC, ~v);
            `CHK(port_c_out, ~v)
            wr(`MSP_OFF_DDRC, v);
            `CHK(port_c_oe, v)
            host.strobe(v ^ 8'h3c);
            rd(`MSP_OFF_LATCH, 1'b0, 1'b1, v ^ 8'h3c);
        end
        // Frozen enable: a strobe pulse while frozen never reaches the latch
        clk_en <= 1'b0;
        host.strobe(~(v ^ 8'h3c));
        clk_en <= 1'b1;
        rd(`MSP_OFF_LATCH, 1'b0, 1'b1, v ^ 8'h3c);
        `CHK(exp_q.size(), 0)
        tally_and_finish;
    end
endmodule : tb
